// ==== inc/qx_map.svh ====
// Overview of operation
// - source peripheral read on when bit set
// - destination peripheral write on when bit set
// - link off leaves used entry untouched
// - link on reloads entry from link set
// - link offset counts from parameter ram base
// - quick transfers start on processor request
// - quick unit has no reload or link
// - hardware never changes quick registers
// - both quick register sets are write-only
// - plain quick writes configure, never submit
// - quick options link bit is reserved
// - pseudo-register write configures and submits
// - one to five writes per submission
// - quick transfers always frame synchronised
// - one request per submission, one frame if 1D, else whole block
// - quick completion can chain another channel
// - quick options field layout
// - irq enable sets pending bit by code
// - frame sync moves frame, else subframe
// - quick sync event is pseudo-register store
`ifndef QX_MAP_SVH
`define QX_MAP_SVH
`define QX_A_PEND_LO 12'h040
`define QX_A_PEND_HI 12'h044
`define QX_A_EVT 12'h048
`define QX_A_STAT 12'h04c
`define QX_A_MISS 12'h050
`define QX_QREG_PAGE 7'h00
`define QX_PSEUDO_PAGE 7'h01
`define QX_PRAM_PAGE 4'h4
`define QX_N_QREG 3'd5
`define QX_W_OPT 3'd0
`define QX_W_CNT 3'd2
`define QX_W_LINK 3'd5
`define QX_ENTRY_WORDS 6'd6
`define QX_PRAM_WORDS 64
`define QX_N_CH 4
`define QX_CHAIN_LIM 6'd4
`define QX_OPT_RST 32'h00000001
`define QX_OPT_MASK 32'hffff6001
`define QX_FRM_DEC 32'h00010000
`define OPT_PRI_HI 31
`define OPT_PRI_LO 29
`define OPT_SDIM 26
`define OPT_DDIM 23
`define OPT_COMPLETION_IRQ_ENABLE 20
`define OPT_SRC_PERIPH_XFER_MODE 3
`define OPT_DST_PERIPH_XFER_MODE 2
`define OPT_LINK 1
`define OPT_FS 0
`define CNT_FRM_HI 31
`define CNT_FRM_LO 16
`define LINK_HI 7
`define LINK_LO 2
`endif

// ==== inc/qx_pkg.sv ====
`include "qx_map.svh"
package qx_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ISSUE, ST_LINK} eng_state_t;
  typedef logic [4:0][31:0] words_t;
  typedef struct packed {
    eng_state_t st;
    words_t qreg;
    logic [3:0] evt;
    logic [3:0] miss;
    logic [1:0] ch;
    logic [2:0] k;
    words_t wbuf;
    logic [5:0] lnk;
    logic [31:0] rdata;
    logic req_v;
    logic [2:0] req_q;
    words_t req_w;
    logic req_whole;
    logic req_pdt_rd;
    logic req_pdt_wr;
    logic req_quick;
  } core_t;
endpackage

// ==== inc/qx_link_if.sv ====
interface qx_link_if;
  logic ram_we;
  logic [5:0] ram_waddr;
  logic [31:0] ram_wdata;
  logic [5:0] ram_raddr_a;
  logic [31:0] ram_rdata_a;
  logic [5:0] ram_raddr_b;
  logic [31:0] ram_rdata_b;
  logic pend_set;
  logic [5:0] pend_code;
  logic [63:0] pend_clr;
  logic [63:0] pend_bits;
  modport core (
    output ram_we, ram_waddr, ram_wdata, ram_raddr_a, ram_raddr_b,
    input ram_rdata_a, ram_rdata_b,
    output pend_set, pend_code, pend_clr,
    input pend_bits
  );
  modport ram (
    input ram_we, ram_waddr, ram_wdata, ram_raddr_a, ram_raddr_b,
    output ram_rdata_a, ram_rdata_b
  );
  modport pend (
    input pend_set, pend_code, pend_clr,
    output pend_bits
  );
endinterface

// ==== hdl/parameter_ram_ram.sv ====
`include "qx_map.svh"
module parameter_ram_ram (
  input wire logic clk, // system clock
  qx_link_if.ram lk // ram ports
);
  logic [31:0] mem [`QX_PRAM_WORDS];

  always_ff @(posedge clk) begin
    if (lk.ram_we) begin
      mem[lk.ram_waddr] <= lk.ram_wdata;
    end
  end

  // both read ports combinational so engine and bus never wait
  assign lk.ram_rdata_a = mem[lk.ram_raddr_a];
  assign lk.ram_rdata_b = mem[lk.ram_raddr_b];
endmodule

// ==== hdl/pend_bits.sv ====
module pend_bits (
  input wire logic clk, // system clock
  input wire logic reset, // async reset, active high
  qx_link_if.pend lk // set, clear and state
);
  logic [63:0] bits_q;
  logic [63:0] bits_d;

  for (genvar i = 0; i < 64; i++) begin : g_bit
    // set wins over a clear in the same cycle
    assign bits_d[i] = (lk.pend_set && lk.pend_code == 6'(i)) || (bits_q[i] && !lk.pend_clr[i]);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bits_q <= 64'h0;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign lk.pend_bits = bits_q;
endmodule

// ==== hdl/quick_xfer_top.sv ====
// Our own choices: the register addresses and the strobed register port.
`include "qx_map.svh"
module quick_xfer_top (
  input wire logic clk, // system clock, 250 MHz
  input wire logic reset, // async reset, active high
  input wire logic [11:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [3:0] chan_evt, // channel sync event pulses
  input wire logic cmpl_valid, // queue finished a transfer
  input wire logic cmpl_irq, // that transfer had irq enable
  input wire logic [5:0] cmpl_code, // its completion code
  output logic req_valid, // request pulse to queues
  output logic [2:0] req_queue, // queue picked by priority
  output qx_pkg::words_t req_word, // opt, src, cnt, dst, idx
  output logic req_whole, // whole frame per request
  output logic req_pdt_rd, // peripheral transfer read
  output logic req_pdt_wr, // peripheral transfer write
  output logic req_quick // request came from quick unit
);
  qx_pkg::core_t s;
  qx_pkg::core_t n;
  qx_pkg::words_t qw;
  qx_link_if lk ();
  logic [2:0] widx;
  logic in_q;
  logic in_ps;
  logic in_pram;
  logic bus_ram_we;
  logic submit;
  logic exh;
  logic two_d;
  logic [5:0] base;
  logic [3:0] chain;
  logic [3:0] event_set_reg;
  logic [3:0] new_evt;
  logic [3:0] evt_clr;
  logic [3:0] miss_clr;
  logic pick;
  logic [1:0] pch;

  parameter_ram_ram u_ram (
    .clk(clk),
    .lk(lk)
  );

  pend_bits u_pend (
    .clk(clk),
    .reset(reset),
    .lk(lk)
  );

  assign widx = addr[4:2];
  assign in_q = addr[11:5] == `QX_QREG_PAGE && widx < `QX_N_QREG;
  assign in_ps = addr[11:5] == `QX_PSEUDO_PAGE && widx < `QX_N_QREG;
  assign in_pram = addr[11:8] == `QX_PRAM_PAGE;
  assign bus_ram_we = wr && in_pram;
  // only a pseudo-register store starts a quick transfer
  assign submit = wr && in_ps;
  assign base = 6'(s.ch) * `QX_ENTRY_WORDS;
  assign two_d = s.wbuf[0][`OPT_SDIM] || s.wbuf[0][`OPT_DDIM];
  // set used up: a frame-synced block, or last frame
  assign exh = (s.wbuf[0][`OPT_FS] && two_d) || s.wbuf[2][`CNT_FRM_HI:`CNT_FRM_LO] == 16'h0;

  // quick register image with this cycle's store applied
  always_comb begin
    qw = s.qreg;
    if (wr && (in_q || in_ps)) begin
      if (widx == `QX_W_OPT) begin
        qw[widx] = wdata & `QX_OPT_MASK;
      end else begin
        qw[widx] = wdata;
      end
    end
  end

  // completion with irq enable and a code below channel count triggers that channel
  always_comb begin
    chain = 4'h0;
    if (cmpl_valid && cmpl_irq && cmpl_code < `QX_CHAIN_LIM) begin
      chain = 4'h1 << cmpl_code[1:0];
    end
    event_set_reg = 4'h0;
    if (wr && addr == `QX_A_EVT) begin
      event_set_reg = wdata[3:0];
    end
    new_evt = chan_evt | chain | event_set_reg;
  end

  // lowest pending channel is served first
  always_comb begin
    pick = 1'b0;
    pch = 2'h0;
    for (int i = `QX_N_CH - 1; i >= 0; i--) begin
      if (s.evt[i]) begin
        pick = 1'b1;
        pch = 2'(i);
      end
    end
  end

  always_comb begin
    n = s;
    n.req_v = 1'b0;
    n.rdata = 32'h0;
    n.qreg = qw;
    evt_clr = 4'h0;
    miss_clr = 4'h0;
    lk.ram_we = bus_ram_we;
    lk.ram_waddr = addr[7:2];
    lk.ram_wdata = wdata;
    lk.ram_raddr_a = addr[7:2];
    lk.ram_raddr_b = 6'h0;
    lk.pend_set = cmpl_valid && cmpl_irq;
    lk.pend_code = cmpl_code;
    lk.pend_clr = 64'h0;

    if (wr && addr == `QX_A_PEND_LO) begin
      lk.pend_clr[31:0] = wdata;
    end
    if (wr && addr == `QX_A_PEND_HI) begin
      lk.pend_clr[63:32] = wdata;
    end
    if (wr && addr == `QX_A_MISS) begin
      miss_clr = wdata[3:0];
    end

    // quick registers are never readable
    if (rd) begin
      case (addr)
        `QX_A_PEND_LO: n.rdata = lk.pend_bits[31:0];
        `QX_A_PEND_HI: n.rdata = lk.pend_bits[63:32];
        `QX_A_EVT: n.rdata = {28'h0, s.evt};
        `QX_A_STAT: n.rdata = {24'h0, 1'b0, s.st != qx_pkg::ST_IDLE, s.ch, 1'b0, s.k};
        `QX_A_MISS: n.rdata = {28'h0, s.miss};
        default: n.rdata = in_pram ? lk.ram_rdata_a : 32'h0;
      endcase
    end

    // one request per pseudo store, always a whole frame
    if (submit) begin
      n.req_v = 1'b1;
      n.req_quick = 1'b1;
      n.req_q = qw[0][`OPT_PRI_HI:`OPT_PRI_LO];
      n.req_w = qw;
      n.req_w[0][`OPT_FS] = 1'b1;
      n.req_w[0][`OPT_LINK] = 1'b0;
      if (!qw[0][`OPT_SDIM] && !qw[0][`OPT_DDIM]) begin
        n.req_w[2][`CNT_FRM_HI:`CNT_FRM_LO] = 16'h0;
      end
      n.req_whole = 1'b1;
      n.req_pdt_rd = 1'b0;
      n.req_pdt_wr = 1'b0;
    end

    case (s.st)
      qx_pkg::ST_IDLE: begin
        if (pick) begin
          n.ch = pch;
          n.k = 3'h0;
          evt_clr[pch] = 1'b1;
          n.st = qx_pkg::ST_FETCH;
        end
      end
      qx_pkg::ST_FETCH: begin
        lk.ram_raddr_b = base + 6'(s.k);
        if (s.k == `QX_W_LINK) begin
          n.lnk = lk.ram_rdata_b[`LINK_HI:`LINK_LO];
          n.st = qx_pkg::ST_ISSUE;
        end else begin
          n.wbuf[s.k] = lk.ram_rdata_b;
          n.k = s.k + 3'h1;
        end
      end
      qx_pkg::ST_ISSUE: begin
        // quick submit owns the request slot, bus owns ram port
        if (!submit && !bus_ram_we) begin
          n.req_v = 1'b1;
          n.req_quick = 1'b0;
          n.req_q = s.wbuf[0][`OPT_PRI_HI:`OPT_PRI_LO];
          n.req_w = s.wbuf;
          n.req_whole = s.wbuf[0][`OPT_FS];
          n.req_pdt_rd = s.wbuf[0][`OPT_SRC_PERIPH_XFER_MODE];
          n.req_pdt_wr = s.wbuf[0][`OPT_DST_PERIPH_XFER_MODE];
          if (!exh) begin
            lk.ram_we = 1'b1;
            lk.ram_waddr = base + 6'(`QX_W_CNT);
            lk.ram_wdata = s.wbuf[2] - `QX_FRM_DEC;
            n.st = qx_pkg::ST_IDLE;
          end else if (s.wbuf[0][`OPT_LINK]) begin
            n.k = 3'h0;
            n.st = qx_pkg::ST_LINK;
          end else begin
            n.st = qx_pkg::ST_IDLE;
          end
        end
      end
      qx_pkg::ST_LINK: begin
        // copy the linked set word by word over the entry
        if (!bus_ram_we) begin
          lk.ram_raddr_b = s.lnk + 6'(s.k);
          lk.ram_we = 1'b1;
          lk.ram_waddr = base + 6'(s.k);
          lk.ram_wdata = lk.ram_rdata_b;
          if (s.k == `QX_W_LINK) begin
            n.st = qx_pkg::ST_IDLE;
          end else begin
            n.k = s.k + 3'h1;
          end
        end
      end
      default: begin
        n.st = qx_pkg::ST_IDLE;
      end
    endcase

    // new events beat the clear; a repeat while pending is a miss
    n.evt = (s.evt & ~evt_clr) | new_evt;
    n.miss = (s.miss & ~miss_clr) | (new_evt & s.evt & ~evt_clr);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.qreg[0] <= `QX_OPT_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign req_valid = s.req_v;
  assign req_queue = s.req_q;
  assign req_word = s.req_w;
  assign req_whole = s.req_whole;
  assign req_pdt_rd = s.req_pdt_rd;
  assign req_pdt_wr = s.req_pdt_wr;
  assign req_quick = s.req_quick;
endmodule

// ==== bench/queue_model.sv ====
module queue_model #(
  parameter int LAT = 3
) (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic req_valid, // request in
  input wire qx_pkg::words_t req_word, // request words
  output logic cmpl_valid, // done pulse
  output logic cmpl_irq, // irq enable of done one
  output logic [5:0] cmpl_code // its code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] t_q;
  logic [31:0] o_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t_q <= 4'h0;
      o_q <= 32'h0;
    end else if (req_valid) begin
      t_q <= 4'(LAT);
      o_q <= req_word[0];
    end else if (t_q != 4'h0) begin
      t_q <= t_q - 4'h1;
    end
  end
  assign cmpl_valid = (t_q == 4'h1);
  // lines invert outside the done pulse
  assign cmpl_irq = cmpl_valid ? o_q[20] : ~o_q[20];
  assign cmpl_code = cmpl_valid ? {o_q[14:13], o_q[19:16]} : ~{o_q[14:13], o_q[19:16]};
endmodule

// ==== bench/quick_xfer_sva.sv ====
module quick_xfer_chk (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic [11:0] addr, // address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic req_valid, // request
  input wire logic [2:0] req_queue, // queue
  input wire qx_pkg::words_t req_word, // words
  input wire logic req_whole, // whole frame
  input wire logic req_quick // quick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire [2:0] wi = addr[4:2];
  wire ps = wr && addr[11:5] == 7'h01 && wi < 3'h5;
  wire qs = wr && addr[11:5] == 7'h00 && wi < 3'h5;
  wire qr = req_valid && req_quick;
  a_submit_req: assert property (ps |=> qr && req_whole)
    else $error("pseudo store gave no quick request");
  a_plain_cfg: assert property (qs |=> !qr)
    else $error("plain store submitted");
  a_only_pseudo: assert property (qr |-> $past(ps))
    else $error("quick request without store");
  a_queue_pri: assert property (qr |-> req_queue == req_word[0][31:29])
    else $error("queue not from priority");
  a_opt_forced: assert property (qr |-> req_word[0][1:0] == 2'h1)
    else $error("option low bits wrong");
  a_word_store: assert property (ps && wi inside {3'h1, 3'h3, 3'h4} |=>
    req_word[$past(wi)] == $past(wdata))
    else $error("stored word not sent");
  a_req_hold: assert property (!req_valid |-> $stable(req_word) && $stable(req_queue))
    else $error("request words changed");
  a_read_quiet: assert property (rd && addr < 12'h040 |=> rdata == 32'h0)
    else $error("quick register readable");
endmodule
bind quick_xfer_top quick_xfer_chk chk_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .req_valid(req_valid), .req_queue(req_queue),
  .req_word(req_word), .req_whole(req_whole), .req_quick(req_quick));

// ==== bench/quick_dma_request_submit_bench.sv ====
module quick_dma_request_submit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] chan_evt = 4'h0;
  logic [31:0] rdata, d;
  logic req_valid, req_whole, req_pdt_rd, req_pdt_wr, req_quick, cv, ci;
  logic [2:0] req_queue;
  logic [5:0] cc;
  qx_pkg::words_t req_word;
  logic [31:0] e0 [6] = '{32'hb, 32'h1, 32'h0, 32'h2, 32'h0, 32'h30};
  logic [31:0] e1 [6] = '{32'h6, 32'h5, 32'h30000, 32'h7, 32'h0, 32'h0};
  int errors = 0;
  int comparisons = 0;
  int nreq = 0;
  int cyc = 0;
  initial forever #2 clk = ~clk;
  quick_xfer_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chan_evt(chan_evt), .cmpl_valid(cv), .cmpl_irq(ci), .cmpl_code(cc),
    .req_valid(req_valid), .req_queue(req_queue), .req_word(req_word), .req_whole(req_whole),
    .req_pdt_rd(req_pdt_rd), .req_pdt_wr(req_pdt_wr), .req_quick(req_quick));
  queue_model part_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req_word(req_word),
    .cmpl_valid(cv), .cmpl_irq(ci), .cmpl_code(cc));
  wire [31:0] flags = {28'h0, req_quick, req_whole, req_pdt_rd, req_pdt_wr};
  always @(negedge clk) begin
    if (req_valid === 1'b1) nreq++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr32(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd32(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task evt0;
    @(posedge clk);
    chan_evt <= 4'h1;
    @(posedge clk);
    chan_evt <= 4'h0;
    repeat (14) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // four plain stores, then the fifth through its pseudo register
    wr32(12'h000, 32'ha0000003);
    wr32(12'h004, 32'h11110000);
    wr32(12'h008, 32'h00040008);
    wr32(12'h00c, 32'h22220000);
    repeat (2) @(posedge clk);
    chk("plain_nreq", nreq, 32'd0);
    wr32(12'h030, 32'h00040004);
    repeat (2) @(posedge clk);
    chk("nreq", nreq, 32'd1);
    chk("queue", {29'h0, req_queue}, 32'h5);
    chk("opt", req_word[0], 32'ha0000001);
    chk("src", req_word[1], 32'h11110000);
    chk("cnt", req_word[2], 32'h00000008);
    chk("dst", req_word[3], 32'h22220000);
    chk("flags", flags, 32'hc);
    // back to back pseudo stores, other words reused
    @(posedge clk);
    addr <= 12'h024;
    wdata <= 32'h33330000;
    wr <= 1'b1;
    @(posedge clk);
    addr <= 12'h02c;
    wdata <= 32'h44440000;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("nreq2", nreq, 32'd3);
    chk("src2", req_word[1], 32'h33330000);
    chk("dst2", req_word[3], 32'h44440000);
    chk("idx2", req_word[4], 32'h00040004);
    chk("opt2", req_word[0], 32'ha0000001);
    rd32(12'h000);
    chk("rd_quick", d, 32'h0);
    rd32(12'h020);
    chk("rd_pseudo", d, 32'h0);
    rd32(12'h0f0);
    chk("rd_unmapped", d, 32'h0);
    // completion code 37 with irq, then irq off
    wr32(12'h020, 32'h00154001);
    repeat (8) @(posedge clk);
    rd32(12'h044);
    chk("pend_on", d, 32'h20);
    wr32(12'h044, 32'h20);
    wr32(12'h020, 32'h00054001);
    repeat (8) @(posedge clk);
    rd32(12'h044);
    chk("pend_off", d, 32'h0);
    // channel 0 exhausted with link at byte offset 0x30
    for (int i = 0; i < 6; i++) begin
      wr32(12'h400 + 12'(4 * i), e0[i]);
      wr32(12'h430 + 12'(4 * i), e1[i]);
    end
    evt0();
    chk("nreq3", nreq, 32'd6);
    chk("ch_flags", flags, 32'h6);
    rd32(12'h400);
    chk("reload_opt", d, 32'h6);
    rd32(12'h408);
    chk("reload_cnt", d, 32'h30000);
    evt0();
    chk("ch_flags2", flags, 32'h1);
    rd32(12'h408);
    chk("dec_cnt", d, 32'h20000);
    // quick completion with code 0 chains channel 0
    wr32(12'h020, 32'h00100001);
    repeat (16) @(posedge clk);
    chk("nreq_chain", nreq, 32'd9);
    chk("chain_flags", flags, 32'h1);
    rd32(12'h408);
    chk("chain_cnt", d, 32'h10000);
    rd32(12'h040);
    chk("pend_chain", d, 32'h1);
    report_and_stop();
  end
endmodule
